// >>> hw/bdec_error_capture.sv
`timescale 1ns/100ps
// Function
// - Unused status bits read zero
// - Halt line with enable sets bit 15
// - Power-good negation with halt action sets 14
// - Write-one, io reset, power-up, halted negation clear
// - Zero writes ignored; byte lanes accepted
// - Demand cycle no reply sets bit 7
// - Ack and prefetch cycles never set 7,5,2
// - Demand read parity error sets bit 5
// - Local memory read error sets bit 4, reported
// - Capturing error with flag already set: lost
// - Demand cycle grant timeout sets bit 2
// - Bus page valid only with 5 or 7
// - Bus address 21:9 into bits 12:0
// - Page registers read-only, word reads
// - Write to bus page raises machine check
// - Write to DMA page raises machine check
// - DMA page valid only with 4 or 0
// - DMA page latched until 4,0 cleared
// - Mapped address 28:9 into bits 19:0
module bdec_error_capture (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Local processor register port
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic [3:0] regByteEnable,
  output logic [31:0] regReadData,
  output logic regReadValid,
  output logic machineCheck,
  // Configuration and system state
  input wire logic haltLineEnable,
  input wire logic dcokHaltAction,
  input wire logic processorHalted,
  input wire logic ioResetWrite,
  // Backplane lines
  input wire logic backplaneHaltLine,
  input wire logic backplanePowerGood,
  // Backplane cycle outcome
  input wire logic busCycleDone,
  input wire bdec_pkg::bdec_cycle_type busCycleKind,
  input wire logic busNoReply,
  input wire logic busParityError,
  input wire logic busNoGrant,
  input wire logic [21:0] busAddress,
  // DMA side events
  input wire logic memoryReadError,
  input wire logic dmaNonexistent,
  input wire logic [28:0] mappedAddress,
  // Report to interprocessor comm register
  output logic memErrorReport
);

  typedef struct packed {
    logic [15:0] status;
    logic powerGoodPrev;
    logic [31:0] readData;
    logic readValid;
    logic machineCheck;
    logic memReport;
  } bdec_state_type;

  bdec_state_type state_reg;
  bdec_state_type state_next;

  logic [1:0] resetSync_reg;
  logic resetSync_b;
  logic [bdec_pkg::BUS_PAGE_WIDTH-1:0] busPage;
  logic [bdec_pkg::DMA_PAGE_WIDTH-1:0] dmaPage;
  logic demandCycle;
  logic setMasterTimeout;
  logic setParity;
  logic setNoGrant;
  logic setMemory;
  logic setNxm;
  logic setHalt;
  logic setPower;
  logic setLost;
  logic powerGoodFall;
  logic clearAll;
  logic busLoad;
  logic dmaLoad;
  logic [15:0] setVector;
  logic [15:0] clearVector;
  logic [31:0] writeLanes;

  function automatic logic [31:0] laneMask(input logic [3:0] lanes);
    logic [31:0] mask;
    mask = '0;
    for (int i = 0; i < 4; i++) begin
      mask[8*i +: 8] = {8{lanes[i]}};
    end
    return mask;
  endfunction

  function automatic logic hits(input logic [31:0] addr, input logic [31:0] reg_addr);
    return addr == reg_addr;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resetSync_reg <= 2'h0;
    end else begin
      resetSync_reg <= {resetSync_reg[0], 1'b1};
    end
  end
  assign resetSync_b = resetSync_reg[1];

  always_comb begin
    writeLanes = laneMask(regByteEnable);
    demandCycle = busCycleDone && (busCycleKind == bdec_pkg::DEMAND_READ ||
                                   busCycleKind == bdec_pkg::DEMAND_WRITE);
    setMasterTimeout = demandCycle && busNoReply;
    setParity = busCycleDone && busParityError &&
                busCycleKind == bdec_pkg::DEMAND_READ;
    setNoGrant = demandCycle && busNoGrant;
    setMemory = memoryReadError;
    setNxm = dmaNonexistent;
    setHalt = backplaneHaltLine && haltLineEnable;
    powerGoodFall = state_reg.powerGoodPrev && !backplanePowerGood;
    setPower = powerGoodFall && dcokHaltAction;
    setLost = (setMasterTimeout || setParity || setMemory || setNxm) &&
              |(state_reg.status & bdec_pkg::CAPTURE_MASK);
    busLoad = (setMasterTimeout || setParity) &&
              !state_reg.status[bdec_pkg::MASTER_TIMEOUT_BIT] &&
              !state_reg.status[bdec_pkg::PARITY_BIT];
    dmaLoad = (setMemory || setNxm) &&
              !state_reg.status[bdec_pkg::MEMORY_BIT] &&
              !state_reg.status[bdec_pkg::DMA_NXM_BIT];
    setVector = '0;
    setVector[bdec_pkg::HALT_BIT] = setHalt;
    setVector[bdec_pkg::POWER_BIT] = setPower;
    setVector[bdec_pkg::MASTER_TIMEOUT_BIT] = setMasterTimeout;
    setVector[bdec_pkg::PARITY_BIT] = setParity;
    setVector[bdec_pkg::MEMORY_BIT] = setMemory;
    setVector[bdec_pkg::LOST_BIT] = setLost;
    setVector[bdec_pkg::NO_GRANT_BIT] = setNoGrant;
    setVector[bdec_pkg::DMA_NXM_BIT] = setNxm;
    clearAll = ioResetWrite || (powerGoodFall && processorHalted);
    clearVector = '0;
    if (clearAll) begin
      clearVector = '1;
    end else if (regWrite && hits(regAddr, bdec_pkg::STATUS_ADDR)) begin
      clearVector = regWriteData[15:0] & writeLanes[15:0];
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.powerGoodPrev = backplanePowerGood;
    state_next.status = ((state_reg.status & ~clearVector) | setVector) &
                        bdec_pkg::STATUS_IMPL_MASK;
    state_next.readValid = regRead;
    state_next.readData = bdec_pkg::WORD_ZERO;
    if (regRead) begin
      if (hits(regAddr, bdec_pkg::STATUS_ADDR)) begin
        state_next.readData = {16'h0000, state_reg.status};
      end else if (hits(regAddr, bdec_pkg::BUS_PAGE_ADDR)) begin
        state_next.readData = {19'h00000, busPage};
      end else if (hits(regAddr, bdec_pkg::DMA_PAGE_ADDR)) begin
        state_next.readData = {12'h000, dmaPage};
      end
    end
    state_next.machineCheck = regWrite &&
                              (hits(regAddr, bdec_pkg::BUS_PAGE_ADDR) ||
                               hits(regAddr, bdec_pkg::DMA_PAGE_ADDR));
    state_next.memReport = setMemory;
  end

  always_ff @(posedge clock or negedge resetSync_b) begin
    if (!resetSync_b) begin
      state_reg.status <= bdec_pkg::STATUS_RESET;
      state_reg.powerGoodPrev <= 1'b1;
      state_reg.readData <= bdec_pkg::WORD_ZERO;
      state_reg.readValid <= 1'b0;
      state_reg.machineCheck <= 1'b0;
      state_reg.memReport <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus side page, write path has no access to it
  bdec_page_capture #(
    .WIDTH(bdec_pkg::BUS_PAGE_WIDTH)
  ) busCapture (
    .clock(clock),
    .resetSync_b(resetSync_b),
    .load(busLoad),
    .pageIn(busAddress[bdec_pkg::BUS_PAGE_LSB +: bdec_pkg::BUS_PAGE_WIDTH]),
    .page(busPage)
  );

  bdec_page_capture #(
    .WIDTH(bdec_pkg::DMA_PAGE_WIDTH)
  ) dmaCapture (
    .clock(clock),
    .resetSync_b(resetSync_b),
    .load(dmaLoad),
    .pageIn(mappedAddress[bdec_pkg::DMA_PAGE_LSB +: bdec_pkg::DMA_PAGE_WIDTH]),
    .page(dmaPage)
  );

  assign regReadData = state_reg.readData;
  assign regReadValid = state_reg.readValid;
  assign machineCheck = state_reg.machineCheck;
  assign memErrorReport = state_reg.memReport;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetSync_b);

  a_unused_bits_zero: assert property (
    (state_reg.status & ~bdec_pkg::STATUS_IMPL_MASK) == 16'h0000)
    else $error("unused status bit set");

  a_halt_sets: assert property (
    backplaneHaltLine && haltLineEnable |=> state_reg.status[bdec_pkg::HALT_BIT])
    else $error("halt flag not set");

  a_power_sets: assert property (
    $fell(backplanePowerGood) && dcokHaltAction && $past(resetSync_b)
    |=> state_reg.status[bdec_pkg::POWER_BIT])
    else $error("power flag not set");

  a_io_reset_register_clears: assert property (
    ioResetWrite && setVector == 16'h0000 |=> state_reg.status == 16'h0000)
    else $error("io reset did not clear");

  a_zero_write_keeps: assert property (
    regWrite && regAddr == bdec_pkg::STATUS_ADDR && regWriteData == 32'h0 && !clearAll
    |=> (state_reg.status & $past(state_reg.status)) == $past(state_reg.status))
    else $error("zero write changed a flag");

  a_ack_no_flags: assert property (
    busCycleDone && (busCycleKind == bdec_pkg::INTR_ACK ||
                     busCycleKind == bdec_pkg::PREFETCH_READ)
    && !state_reg.status[bdec_pkg::MASTER_TIMEOUT_BIT] && !clearAll
    |=> !state_reg.status[bdec_pkg::MASTER_TIMEOUT_BIT])
    else $error("ack or prefetch set timeout");

  a_lost_flag: assert property (
    setParity && state_reg.status[bdec_pkg::DMA_NXM_BIT]
    |=> state_reg.status[bdec_pkg::LOST_BIT])
    else $error("lost error not flagged");

  a_bus_page_load: assert property (
    setMasterTimeout && !state_reg.status[bdec_pkg::MASTER_TIMEOUT_BIT]
    && !state_reg.status[bdec_pkg::PARITY_BIT]
    ##1 regRead && regAddr == bdec_pkg::BUS_PAGE_ADDR
    |=> regReadData == {19'h00000, $past(busAddress[21:9], 2)})
    else $error("bus page not captured");

  a_machine_check: assert property (
    regWrite && regAddr == bdec_pkg::BUS_PAGE_ADDR |=> machineCheck)
    else $error("no machine check");

  a_dma_page_hold: assert property (
    state_reg.status[bdec_pkg::MEMORY_BIT] |=> $stable(dmaPage))
    else $error("dma page overwritten");

  a_set_wins: assert property (
    setParity && regWrite && regAddr == bdec_pkg::STATUS_ADDR
    |=> state_reg.status[bdec_pkg::PARITY_BIT])
    else $error("set lost to clear");

  a_timeout_sets: assert property (
    busCycleDone && busNoReply && (busCycleKind == bdec_pkg::DEMAND_READ ||
                                   busCycleKind == bdec_pkg::DEMAND_WRITE)
    |=> state_reg.status[bdec_pkg::MASTER_TIMEOUT_BIT])
    else $error("timeout flag not set");

  a_parity_sets: assert property (
    busCycleDone && busParityError && busCycleKind == bdec_pkg::DEMAND_READ
    |=> state_reg.status[bdec_pkg::PARITY_BIT])
    else $error("parity flag not set");

  a_grant_sets: assert property (
    busCycleDone && busNoGrant && (busCycleKind == bdec_pkg::DEMAND_READ ||
                                   busCycleKind == bdec_pkg::DEMAND_WRITE)
    |=> state_reg.status[bdec_pkg::NO_GRANT_BIT])
    else $error("grant flag not set");

  a_ack_no_others: assert property (
    busCycleDone && (busCycleKind == bdec_pkg::INTR_ACK ||
                     busCycleKind == bdec_pkg::PREFETCH_READ)
    && !state_reg.status[bdec_pkg::PARITY_BIT] && !state_reg.status[bdec_pkg::NO_GRANT_BIT]
    |=> !state_reg.status[bdec_pkg::PARITY_BIT] && !state_reg.status[bdec_pkg::NO_GRANT_BIT])
    else $error("ack or prefetch set parity or grant");

  a_nxm_sets: assert property (
    dmaNonexistent |=> state_reg.status[bdec_pkg::DMA_NXM_BIT])
    else $error("dma nonexistent flag not set");

  a_mem_report: assert property (
    memoryReadError |=> memErrorReport && state_reg.status[bdec_pkg::MEMORY_BIT])
    else $error("memory error not reported");

  a_dma_page_load: assert property (
    (memoryReadError || dmaNonexistent) && !state_reg.status[bdec_pkg::MEMORY_BIT]
    && !state_reg.status[bdec_pkg::DMA_NXM_BIT]
    |=> dmaPage == $past(mappedAddress[bdec_pkg::DMA_PAGE_LSB +: bdec_pkg::DMA_PAGE_WIDTH]))
    else $error("dma page not captured");

  a_dma_machine_check: assert property (
    regWrite && regAddr == bdec_pkg::DMA_PAGE_ADDR |=> machineCheck)
    else $error("no machine check on dma page");

  c_timeout: cover property (setMasterTimeout ##1 regRead);
  c_lost: cover property (setLost);
  c_dma_capture: cover property (dmaLoad ##[1:20] regRead && regAddr == bdec_pkg::DMA_PAGE_ADDR);
  c_set_clear: cover property (setHalt && clearVector[bdec_pkg::HALT_BIT]);

endmodule

// >>> hw/bdec_page_capture.sv
`timescale 1ns/100ps
module bdec_page_capture #(
  parameter int WIDTH = 13
) (
  // Clock and synchronised reset
  input wire logic clock,
  input wire logic resetSync_b,
  // Capture control
  input wire logic load,
  input wire logic [WIDTH-1:0] pageIn,
  // Captured page
  output logic [WIDTH-1:0] page
);

  typedef struct packed {
    logic [WIDTH-1:0] page;
  } bdec_capture_type;

  bdec_capture_type state_reg;
  bdec_capture_type state_next;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.page = pageIn;
    end
  end

  always_ff @(posedge clock or negedge resetSync_b) begin
    if (!resetSync_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign page = state_reg.page;

endmodule

// >>> hw/bdec_pkg.sv
package bdec_pkg;

  // Register addresses on the local processor port
  localparam logic [31:0] STATUS_ADDR = 32'h20080004;
  localparam logic [31:0] BUS_PAGE_ADDR = 32'h20080008;
  localparam logic [31:0] DMA_PAGE_ADDR = 32'h2008000c;

  // Status register bit positions
  localparam int HALT_BIT = 15;
  localparam int POWER_BIT = 14;
  localparam int MASTER_TIMEOUT_BIT = 7;
  localparam int PARITY_BIT = 5;
  localparam int MEMORY_BIT = 4;
  localparam int LOST_BIT = 3;
  localparam int NO_GRANT_BIT = 2;
  localparam int DMA_NXM_BIT = 0;

  localparam int STATUS_WIDTH = 16;
  localparam logic [15:0] STATUS_IMPL_MASK = 16'hc0bd;
  localparam logic [15:0] CAPTURE_MASK = 16'h00b1;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Capture register layouts
  localparam int BUS_PAGE_WIDTH = 13;
  localparam int BUS_PAGE_LSB = 9;
  localparam int DMA_PAGE_WIDTH = 20;
  localparam int DMA_PAGE_LSB = 9;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [3:0] WORD_LANES = 4'hf;

  typedef enum logic [1:0] {
    DEMAND_READ,
    DEMAND_WRITE,
    INTR_ACK,
    PREFETCH_READ
  } bdec_cycle_type;

endpackage

// >>> tb/bdec_bus_partner.sv
`timescale 1ns/100ps
module bdec_bus_partner (
  // Bench request
  input wire logic clock,
  input wire logic start,
  input wire logic [3:0] delay,
  input wire logic [2:0] faults,
  input wire logic [21:0] address,
  input wire bdec_pkg::bdec_cycle_type kind,
  // Cycle outcome
  output logic busCycleDone,
  output bdec_pkg::bdec_cycle_type busCycleKind,
  output logic [2:0] busFaults,
  output logic [21:0] busAddress
);
  logic [4:0] countReg = 5'h00;
  logic [26:0] heldReg = 27'h0000000;
  always @(posedge clock) begin
    if (start) begin
      countReg <= {1'b0, delay} + 5'h01;
      heldReg <= {kind, faults, address};
    end else if (countReg != 5'h00) begin
      countReg <= countReg - 5'h01;
    end
  end
  // Off the reply cycle the lines show the inverse of the last value
  assign busCycleDone = countReg == 5'h01;
  assign busCycleKind = bdec_pkg::bdec_cycle_type'(busCycleDone ? heldReg[26:25] : ~heldReg[26:25]);
  assign busFaults = busCycleDone ? heldReg[24:22] : ~heldReg[24:22];
  assign busAddress = busCycleDone ? heldReg[21:0] : ~heldReg[21:0];
endmodule

// >>> tb/test_bus_dma_error_capture.sv
`timescale 1ns/100ps
module test_bus_dma_error_capture;
  typedef struct {logic [1:0] kind; logic [31:0] data;} bdec_note_type;
  bdec_note_type notes[$];
  bdec_note_type got;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic regRead = 1'b0;
  logic regWrite = 1'b0;
  logic [31:0] regAddr = 32'h00000000;
  logic [31:0] regWriteData = 32'h00000000;
  logic [3:0] regByteEnable = 4'h0;
  logic [31:0] regReadData;
  logic regReadValid, machineCheck, memErrorReport, busCycleDone;
  logic haltLineEnable = 1'b0;
  logic dcokHaltAction = 1'b0;
  logic processorHalted = 1'b0;
  logic ioResetWrite = 1'b0;
  logic backplaneHaltLine = 1'b0;
  logic backplanePowerGood = 1'b1;
  logic memoryReadError = 1'b0;
  logic dmaNonexistent = 1'b0;
  logic [28:0] mappedAddress = 29'h00000000;
  logic pStart = 1'b0;
  logic [3:0] pDelay = 4'h0;
  logic [2:0] pFaults = 3'h0;
  logic [21:0] pAddr = 22'h000000;
  bdec_pkg::bdec_cycle_type pKind = bdec_pkg::DEMAND_READ;
  bdec_pkg::bdec_cycle_type busCycleKind;
  logic [2:0] busFaults;
  logic [21:0] busAddress;
  logic [15:0] stat = 16'h0000;
  logic [31:0] busPage = 32'h00000000;
  logic [31:0] dmaPage = 32'h00000000;
  logic [31:0] r;
  integer seed = 83358;
  int miscompares = 0;
  int comparisons = 0;

  bdec_error_capture dut (.clock(clock), .rst_b(rst_b), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWriteData(regWriteData), .regByteEnable(regByteEnable),
    .regReadData(regReadData), .regReadValid(regReadValid), .machineCheck(machineCheck),
    .haltLineEnable(haltLineEnable), .dcokHaltAction(dcokHaltAction),
    .processorHalted(processorHalted), .ioResetWrite(ioResetWrite),
    .backplaneHaltLine(backplaneHaltLine), .backplanePowerGood(backplanePowerGood),
    .busCycleDone(busCycleDone), .busCycleKind(busCycleKind), .busNoReply(busFaults[2]),
    .busParityError(busFaults[1]), .busNoGrant(busFaults[0]), .busAddress(busAddress),
    .memoryReadError(memoryReadError), .dmaNonexistent(dmaNonexistent),
    .mappedAddress(mappedAddress), .memErrorReport(memErrorReport));
  bdec_bus_partner partner (.clock(clock), .start(pStart), .delay(pDelay), .faults(pFaults),
    .address(pAddr), .kind(pKind), .busCycleDone(busCycleDone), .busCycleKind(busCycleKind),
    .busFaults(busFaults), .busAddress(busAddress));

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic bad(input string msg);
    $display("CHECK FAILED at %0t: %s", $time, msg);
    miscompares++;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick;
    @(posedge clock);
    #2;
  endtask

  // Result watcher: kind 0 read data, 1 machine check, 2 memory error report
  always @(negedge clock) begin
    if (regReadValid === 1'b1 || machineCheck === 1'b1 || memErrorReport === 1'b1) begin
      comparisons++;
      if (notes.size() == 0) begin
        bad("unexpected result");
      end else begin
        got = notes.pop_front();
        if (got.kind !== {memErrorReport, machineCheck}) bad("wrong result kind");
        if (got.kind == 2'h0 && regReadData !== got.data) bad("read data mismatch");
      end
    end
  end

  task automatic rd(input logic [31:0] a, input logic [31:0] d);
    notes.push_back('{2'h0, d});
    regRead = 1'b1;
    regAddr = a;
    tick;
    regRead = 1'b0;
    tick;
  endtask

  task automatic chk;
    rd(bdec_pkg::STATUS_ADDR, {16'h0000, stat});
    rd(bdec_pkg::BUS_PAGE_ADDR, busPage);
    rd(bdec_pkg::DMA_PAGE_ADDR, dmaPage);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    if (a != bdec_pkg::STATUS_ADDR) notes.push_back('{2'h1, 32'h0});
    else stat = stat & ~(d[15:0] & {{8{be[1]}}, {8{be[0]}}});
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    regByteEnable = be;
    tick;
    regWrite = 1'b0;
    tick;
  endtask

  // Model of flag setting, lost error and page capture
  task automatic record(input logic [15:0] s, input logic [31:0] bp, input logic [31:0] dp);
    if ((s & bdec_pkg::CAPTURE_MASK) != 0 && (stat & bdec_pkg::CAPTURE_MASK) != 0) stat[3] = 1'b1;
    if ((s & 16'h00a0) != 0 && (stat & 16'h00a0) == 0) busPage = bp;
    if ((s & 16'h0011) != 0 && (stat & 16'h0011) == 0) dmaPage = dp;
    stat = stat | s;
  endtask

  task automatic cyc(input bdec_pkg::bdec_cycle_type k, input logic [2:0] f,
      input logic [21:0] a, input logic [3:0] dl);
    logic [15:0] s;
    int n;
    s = 16'h0000;
    if (k == bdec_pkg::DEMAND_READ || k == bdec_pkg::DEMAND_WRITE) begin
      s[7] = f[2];
      s[5] = f[1] && k == bdec_pkg::DEMAND_READ;
      s[2] = f[0];
    end
    record(s, {19'h00000, a[21:9]}, dmaPage);
    pKind = k;
    pFaults = f;
    pAddr = a;
    pDelay = dl;
    pStart = 1'b1;
    tick;
    pStart = 1'b0;
    n = 0;
    while (busCycleDone !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    if (n == 40) begin
      bad("bus cycle never completed");
      report_and_stop;
    end
    tick;
  endtask

  task automatic dmaEvent(input logic me, input logic nx, input logic [28:0] a);
    record({11'h000, me, 3'h0, nx}, busPage, {12'h000, a[28:9]});
    if (me) notes.push_back('{2'h2, 32'h0});
    memoryReadError = me;
    dmaNonexistent = nx;
    mappedAddress = a;
    tick;
    memoryReadError = 1'b0;
    dmaNonexistent = 1'b0;
    mappedAddress = ~a;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    #2 rst_b = 1'b1;
    repeat (4) tick;
    chk;
    rd(32'h20080010, 32'h00000000);
    $display("Test reset values done");
    for (int k = 0; k < 4; k++) begin
      cyc(bdec_pkg::bdec_cycle_type'(k), 3'h7, 22'h3ffe00 - 22'(k << 9), 4'h0);
      chk;
    end
    $display("Test cycle kinds done");
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'h0, 3'h1: cyc(bdec_pkg::bdec_cycle_type'(r[4:3]), r[7:5], r[29:8], r[11:8]);
        3'h2: dmaEvent(r[3], r[4], r[31:3]);
        3'h3: wr(bdec_pkg::STATUS_ADDR, {16'h0, r[31:16] & bdec_pkg::STATUS_IMPL_MASK}, r[7:4]);
        3'h4: wr(r[3] ? bdec_pkg::BUS_PAGE_ADDR : bdec_pkg::DMA_PAGE_ADDR, r, 4'hf);
        default: begin
          haltLineEnable = r[3];
          backplaneHaltLine = 1'b1;
          tick;
          backplaneHaltLine = 1'b0;
          stat[15] = stat[15] | r[3];
        end
      endcase
      chk;
    end
    $display("Test random traffic done");
    ioResetWrite = 1'b1;
    tick;
    ioResetWrite = 1'b0;
    stat = 16'h0000;
    chk;
    dcokHaltAction = 1'b1;
    backplanePowerGood = 1'b0;
    tick;
    backplanePowerGood = 1'b1;
    stat[14] = 1'b1;
    chk;
    dmaEvent(1'b1, 1'b1, 29'h1abcde00);
    dcokHaltAction = 1'b0;
    processorHalted = 1'b1;
    backplanePowerGood = 1'b0;
    tick;
    backplanePowerGood = 1'b1;
    processorHalted = 1'b0;
    stat = 16'h0000;
    chk;
    $display("Test clear sources done");
    haltLineEnable = 1'b1;
    backplaneHaltLine = 1'b1;
    wr(bdec_pkg::STATUS_ADDR, 32'h00008000, 4'h3);
    backplaneHaltLine = 1'b0;
    stat[15] = 1'b1;
    chk;
    wr(bdec_pkg::STATUS_ADDR, 32'h00008000, 4'h1);
    chk;
    wr(bdec_pkg::STATUS_ADDR, 32'h00008000, 4'h2);
    chk;
    $display("Test set against clear done");
    rst_b = 1'b0;
    tick;
    rst_b = 1'b1;
    stat = 16'h0000;
    busPage = 32'h00000000;
    dmaPage = 32'h00000000;
    repeat (4) tick;
    chk;
    $display("Test mid-run reset done");
    repeat (3) tick;
    if (notes.size() != 0) bad("results missing");
    report_and_stop;
  end
endmodule
